/* File: design/strap_pkg.sv */
// shared constants and carrier types for the control-mode strap decoder
package strap_pkg;

	// decoded control interface
	typedef enum logic [1:0] {
		CTRL_HARDWARE,
		CTRL_SERIAL,
		CTRL_PARALLEL
	} ctrl_mode_e;

	// line code choice in hardware mode
	typedef enum logic [1:0] {
		CODE_AMI,
		CODE_B8ZS,
		CODE_HDB3
	} line_code_e;

	// termination impedance choice in hardware mode
	typedef enum logic [1:0] {
		IMP_75,
		IMP_100,
		IMP_110,
		IMP_120
	} impedance_e;

	// line standard in use
	typedef enum logic [1:0] {
		STD_E1,
		STD_T1,
		STD_J1
	} line_std_e;

	// raw strap pins after synchronisation
	typedef struct packed {
		logic [1:0] level;
		logic mux_sel;
		logic bus_style;
		logic code_sel;
		logic imp_sel;
	} strap_pins_s;

	// decoded strap settings
	typedef struct packed {
		ctrl_mode_e mode;
		logic mux_shared;
		logic strobe_split;
		line_code_e line_code;
		impedance_e impedance;
	} strap_cfg_s;

	// scan pins facing the test logic
	typedef struct packed {
		logic active;
		logic shift_en;
		logic clk;
	} scan_s;

	// register file: offsets
	localparam logic [3:0] MASTER_CONFIG_OFS = 4'h0;
	localparam logic [3:0] CLOCK_CONFIG_OFS = 4'h1;
	localparam logic [3:0] STATUS_OFS = 4'h2;

	// register file: field positions and reset values
	localparam int AUX_EN_BIT = 0;
	localparam int CLK_SEL_W = 3;
	localparam logic [7:0] MASTER_CONFIG_RST = 8'h00;
	localparam logic [7:0] CLOCK_CONFIG_RST = 8'h00;

	// three-level pin encoding: 00 low, 01 mid, 1x high
	localparam logic [1:0] LEVEL_LOW = 2'h0;
	localparam logic [1:0] LEVEL_MID = 2'h1;

	// cycles after reset release before the straps are latched
	localparam int SETTLE_CYCLES = 4;

endpackage

/* File: design/control_mode_strap_decode.sv */
// control-mode strap decoder, auxiliary clock gate and scan pin reuse
//
// Functional notes
// - three-level select: hardware, serial, parallel host
// - parallel mode: multiplex pin high means shared bus
// - parallel mode: bus style low direction-line, high strobes
// - hardware mode: code high AMI, else B8ZS/HDB3
// - impedance 0: 75/100 ohm, 1: 120/110 ohm
// - variant 120 inverts the E1 impedance mapping
// - aux clock driven only when register enables it
// - aux clock always off in hardware mode
// - scan test entered when test select high
// - scan mode reuses loss pin 8 as shift enable
// - scan mode reuses loss pin 7 as scan clock
`timescale 1ns/1ns
`default_nettype none
module control_mode_strap_decode #(
	parameter int DIV_W = 8,
	parameter bit VARIANT_120 = 1'b0
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// strap pins, asynchronous
	input wire strap_pkg::strap_pins_s pins_i,
	input wire logic [1:0] line_std_i,
	// scan pins, asynchronous; test select relies on the board pull-down
	input wire logic scan_mode_i,
	input wire logic loss_pin_7_i,
	input wire logic loss_pin_8_i,
	// loss-of-signal outputs from the detectors
	input wire logic [7:0] loss_detect_i,
	output logic [7:0] loss_of_signal_o,
	output logic [7:0] loss_of_signal_oe_o,
	// register port
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// decoded settings and scan view
	output strap_pkg::strap_cfg_s cfg_o,
	output logic cfg_valid_o,
	output strap_pkg::scan_s scan_o,
	// auxiliary clock pin
	output logic aux_clock_out_o,
	output logic aux_clock_oe_o
);
	import strap_pkg::*;

	// whole module state
	typedef struct packed {
		strap_pins_s pins_m;
		strap_pins_s pins_s;
		logic [1:0] std_m;
		logic [1:0] std_s;
		logic [2:0] scan_m;
		logic [2:0] scan_s;
		logic [2:0] settle;
		logic latched;
		strap_cfg_s cfg;
		logic [7:0] master_config_reg;
		logic [7:0] clock_config_reg;
		logic [7:0] rdata;
		logic [DIV_W-1:0] div_cnt;
		logic aux_clk;
		logic aux_oe;
	} state_s;

	state_s st;
	state_s next_st;
	strap_cfg_s dec;
	logic [DIV_W-1:0] half_period;

	// decode the synchronised straps
	always_comb
	begin
		dec = '0;
		if (st.pins_s.level == LEVEL_LOW)
			dec.mode = CTRL_HARDWARE;
		else if (st.pins_s.level == LEVEL_MID)
			dec.mode = CTRL_SERIAL;
		else
			dec.mode = CTRL_PARALLEL;
		if (dec.mode == CTRL_PARALLEL)
		begin
			dec.mux_shared = st.pins_s.mux_sel;
			dec.strobe_split = st.pins_s.bus_style;
		end
		if (dec.mode == CTRL_HARDWARE)
		begin
			if (st.pins_s.code_sel)
				dec.line_code = CODE_AMI;
			else if (st.std_s == 2'(STD_E1))
				dec.line_code = CODE_HDB3;
			else
				dec.line_code = CODE_B8ZS;
			if (st.std_s == 2'(STD_E1))
				dec.impedance = (st.pins_s.imp_sel ^ VARIANT_120) ? IMP_120 : IMP_75;
			else if (st.std_s == 2'(STD_J1))
				dec.impedance = st.pins_s.imp_sel ? IMP_110 : IMP_100;
			else
				dec.impedance = st.pins_s.imp_sel ? IMP_110 : IMP_100;
		end
	end

	// divider half period from the clock configuration register
	assign half_period = DIV_W'(st.clock_config_reg[CLK_SEL_W-1:0]) + DIV_W'(1);

	// next-state logic
	always_comb
	begin
		next_st = st;
		// two-stage synchronisers for every pin
		next_st.pins_m = pins_i;
		next_st.pins_s = st.pins_m;
		next_st.std_m = line_std_i;
		next_st.std_s = st.std_m;
		next_st.scan_m = {scan_mode_i, loss_pin_8_i, loss_pin_7_i};
		next_st.scan_s = st.scan_m;
		// latch straps once after release, then hold
		if (!st.latched)
		begin
			if (st.settle == 3'(SETTLE_CYCLES - 1))
			begin
				next_st.cfg = dec;
				next_st.latched = 1'b1;
			end
			else
				next_st.settle = st.settle + 3'h1;
		end
		// register writes
		if (wr_i)
		begin
			case (addr_i)
				MASTER_CONFIG_OFS: next_st.master_config_reg = wdata_i;
				CLOCK_CONFIG_OFS: next_st.clock_config_reg = wdata_i;
				default: ;
			endcase
		end
		// register reads, data one cycle later
		if (rd_i)
		begin
			case (addr_i)
				MASTER_CONFIG_OFS: next_st.rdata = st.master_config_reg;
				CLOCK_CONFIG_OFS: next_st.rdata = st.clock_config_reg;
				STATUS_OFS: next_st.rdata = {3'h0, st.latched, st.cfg.strobe_split,
					st.cfg.mux_shared, st.cfg.mode};
				default: next_st.rdata = 8'h00;
			endcase
		end
		else
			next_st.rdata = 8'h00;
		// auxiliary clock: enabled by register, never in hardware mode
		next_st.aux_oe = st.latched && st.master_config_reg[AUX_EN_BIT]
			&& (st.cfg.mode != CTRL_HARDWARE);
		if (!next_st.aux_oe)
		begin
			next_st.div_cnt = '0;
			next_st.aux_clk = 1'b0;
		end
		else if (st.div_cnt + DIV_W'(1) >= half_period)
		begin
			next_st.div_cnt = '0;
			next_st.aux_clk = !st.aux_clk;
		end
		else
			next_st.div_cnt = st.div_cnt + DIV_W'(1);
	end

	// state register
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st <= '0;
			st.master_config_reg <= MASTER_CONFIG_RST;
			st.clock_config_reg <= CLOCK_CONFIG_RST;
		end
		else
			st <= next_st;
	end

	// scan pin reuse
	assign scan_o.active = st.scan_s[2];
	assign scan_o.shift_en = st.scan_s[2] & st.scan_s[1];
	assign scan_o.clk = st.scan_s[2] & st.scan_s[0];

	// loss pins 7 and 8 become inputs during scan
	always_comb
	begin
		loss_of_signal_o = loss_detect_i;
		loss_of_signal_oe_o = 8'hff;
		if (st.scan_s[2])
		begin
			loss_of_signal_o[7:6] = 2'h0;
			loss_of_signal_oe_o[7:6] = 2'h0;
		end
	end

	// outputs
	assign cfg_o = st.cfg;
	assign cfg_valid_o = st.latched;
	assign rdata_o = st.rdata;
	assign aux_clock_out_o = st.aux_clk;
	assign aux_clock_oe_o = st.aux_oe;

	// checks
	a_aux_hw_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st.cfg.mode == CTRL_HARDWARE) |-> !aux_clock_oe_o)
		else $error("aux clock enabled in hardware mode");
	a_aux_needs_en: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		aux_clock_oe_o |-> $past(st.master_config_reg[AUX_EN_BIT]))
		else $error("aux clock driven without enable");
	a_aux_quiet_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!aux_clock_oe_o |-> !aux_clock_out_o)
		else $error("aux clock toggles while disabled");
	a_cfg_held: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		cfg_valid_o |=> (cfg_valid_o && $stable(cfg_o)))
		else $error("latched straps changed");
	a_cfg_latch_time: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(cfg_valid_o) |-> !$past(cfg_valid_o, 3))
		else $error("straps latched too early");
	// parallel port options follow the synchronised pins at the latch edge
	a_mux_select: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(cfg_valid_o) && (cfg_o.mode == CTRL_PARALLEL) |-> cfg_o.mux_shared == $past(st.pins_s.mux_sel))
		else $error("multiplex select decode wrong");
	a_strobe_style: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(cfg_valid_o) && (cfg_o.mode == CTRL_PARALLEL) |-> cfg_o.strobe_split == $past(st.pins_s.bus_style))
		else $error("bus style decode wrong");
	// e1 termination follows the pin, inverted on the 120 ohm variant
	a_e1_impedance: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(cfg_valid_o) && (cfg_o.mode == CTRL_HARDWARE) && ($past(st.std_s) == 2'(STD_E1))
		|-> (cfg_o.impedance == IMP_120) == ($past(st.pins_s.imp_sel) ^ VARIANT_120))
		else $error("e1 impedance decode wrong");
	// scan entry follows the synchronised test select
	a_scan_entry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		scan_o.active |-> $past(st.scan_m[2]))
		else $error("scan entered without test select");
	a_mode_decode: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(cfg_valid_o) |-> (cfg_o.mode == CTRL_HARDWARE) == ($past(st.pins_s.level) == LEVEL_LOW))
		else $error("hardware mode decode wrong");
	a_parallel_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(cfg_o.mode != CTRL_PARALLEL) |-> !(cfg_o.mux_shared || cfg_o.strobe_split))
		else $error("parallel options outside parallel mode");
	a_scan_enable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		scan_o.shift_en |-> (scan_o.active && loss_of_signal_oe_o[7] == 1'b0))
		else $error("scan enable outside scan mode");
	a_scan_clock: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!scan_o.active |-> (!scan_o.clk && loss_of_signal_oe_o[6]))
		else $error("scan clock outside scan mode");
	a_ami_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(cfg_valid_o) && ($past(st.pins_s.level) == LEVEL_LOW) && $past(st.pins_s.code_sel)
		|-> cfg_o.line_code == CODE_AMI)
		else $error("line code decode wrong");

endmodule
`default_nettype wire

/* File: test/strap_board.sv */
// board strap wiring model with the scan select pull-down
`timescale 1ns/1ns
`default_nettype none
module strap_board (
	// wanted strap levels
	input wire strap_pkg::strap_pins_s want_i,
	input wire logic scan_drv_i,
	input wire logic scan_val_i,
	// board pins
	output strap_pkg::strap_pins_s pins_o,
	output logic scan_mode_o
);
	import strap_pkg::*;
	// straps are hard wired; an undriven scan select falls to the pull-down
	assign pins_o = want_i;
	assign scan_mode_o = scan_drv_i ? scan_val_i : 1'b0;
endmodule
`default_nettype wire

/* File: test/control_mode_strap_decode_tb.sv */
// self-checking bench for the control-mode strap decoder
`timescale 1ns/1ns
`default_nettype none
module control_mode_strap_decode_tb;
	import strap_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [5:0] want = 6'h00;
	strap_pins_s pins;
	logic scan_drv = 1'b0;
	logic scan_val = 1'b0;
	logic scan_mode;
	logic [1:0] line_std = 2'h0;
	logic lp7 = 1'b0;
	logic lp8 = 1'b0;
	logic [7:0] loss_det = 8'ha5;
	logic [7:0] los;
	logic [7:0] los_oe;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	strap_cfg_s cfg;
	strap_cfg_s cfg_v120;
	logic cfg_valid;
	scan_s scan;
	logic aux;
	logic aux_oe;
	logic prev;
	int n_fail = 0;
	int compares = 0;
	// free running clock
	always #4 sys_clk_i = ~sys_clk_i;
	// board model and block under test
	strap_board strap_board_i (.want_i(want), .scan_drv_i(scan_drv), .scan_val_i(scan_val), .pins_o(pins),
		.scan_mode_o(scan_mode));
	control_mode_strap_decode control_mode_strap_decode_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.pins_i(pins), .line_std_i(line_std), .scan_mode_i(scan_mode), .loss_pin_7_i(lp7), .loss_pin_8_i(lp8),
		.loss_detect_i(loss_det), .loss_of_signal_o(los), .loss_of_signal_oe_o(los_oe), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cfg_o(cfg), .cfg_valid_o(cfg_valid),
		.scan_o(scan), .aux_clock_out_o(aux), .aux_clock_oe_o(aux_oe));
	// 120 ohm variant on the same pins, only its decoded settings are checked
	control_mode_strap_decode #(.VARIANT_120(1'b1)) control_mode_strap_decode_v120_i (.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i), .pins_i(pins), .line_std_i(line_std), .scan_mode_i(scan_mode), .loss_pin_7_i(lp7),
		.loss_pin_8_i(lp8), .loss_detect_i(loss_det), .loss_of_signal_o(), .loss_of_signal_oe_o(), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(), .cfg_o(cfg_v120), .cfg_valid_o(), .scan_o(),
		.aux_clock_out_o(), .aux_clock_oe_o());
	// verdict and end of run
	task automatic conclude();
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// compare one byte-wide result
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// settle after a number of edges
	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	// register write, one strobe cycle
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk_i);
		wr <= 1'b0;
	endtask
	// register read, data looked at in the following cycle
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk_i);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	// reset with given straps, bounded wait for the latch
	task automatic boot(input logic [5:0] s, input logic [1:0] std);
		int i;
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		want <= s;
		line_std <= std;
		repeat (20) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		for (i = 0; i < 10 && cfg_valid !== 1'b1; i++)
			@(posedge sys_clk_i);
		#1;
		if (cfg_valid !== 1'b1)
		begin
			n_fail++;
			conclude();
		end
	endtask
	// scenarios: straps {level, mux, style, code, imp}
	initial
	begin
		boot(6'b001111, 2'h0);
		chk(cfg, {CTRL_HARDWARE, 2'b00, CODE_AMI, IMP_120});
		chk(cfg_v120, {CTRL_HARDWARE, 2'b00, CODE_AMI, IMP_75});
		want <= 6'b100000;
		wr_reg(MASTER_CONFIG_OFS, 8'h01);
		cycles(6);
		chk(cfg, {CTRL_HARDWARE, 2'b00, CODE_AMI, IMP_120});
		chk({7'h0, aux_oe}, 8'h00);
		scan_drv <= 1'b1;
		scan_val <= 1'b1;
		lp7 <= 1'b1;
		lp8 <= 1'b1;
		cycles(4);
		chk({5'h0, scan}, 8'h07);
		chk({6'h0, los_oe[7:6]}, 8'h00);
		lp8 <= 1'b0;
		cycles(4);
		chk({5'h0, scan}, 8'h05);
		scan_drv <= 1'b0;
		lp8 <= 1'b1;
		cycles(4);
		chk({5'h0, scan}, 8'h00);
		chk(los_oe, 8'hff);
		chk(los, 8'ha5);
		boot(6'b000000, 2'h0);
		chk(cfg, {CTRL_HARDWARE, 2'b00, CODE_HDB3, IMP_75});
		chk(cfg_v120, {CTRL_HARDWARE, 2'b00, CODE_HDB3, IMP_120});
		boot(6'b000000, 2'h1);
		chk(cfg, {CTRL_HARDWARE, 2'b00, CODE_B8ZS, IMP_100});
		chk(cfg_v120, {CTRL_HARDWARE, 2'b00, CODE_B8ZS, IMP_100});
		boot(6'b000011, 2'h2);
		chk(cfg, {CTRL_HARDWARE, 2'b00, CODE_AMI, IMP_110});
		boot(6'b011111, 2'h0);
		chk(cfg, {CTRL_SERIAL, 6'h00});
		boot(6'b101000, 2'h0);
		chk(cfg, {CTRL_PARALLEL, 2'b10, 4'h0});
		rd_reg(STATUS_OFS, 8'h16);
		boot(6'b110100, 2'h0);
		chk(cfg, {CTRL_PARALLEL, 2'b01, 4'h0});
		rd_reg(STATUS_OFS, 8'h1a);
		rd_reg(4'hf, 8'h00);
		chk({7'h0, aux_oe}, 8'h00);
		wr_reg(CLOCK_CONFIG_OFS, 8'h00);
		wr_reg(MASTER_CONFIG_OFS, 8'h01);
		rd_reg(MASTER_CONFIG_OFS, 8'h01);
		chk({7'h0, aux_oe}, 8'h01);
		prev = aux;
		cycles(1);
		chk({7'h0, aux}, {7'h0, ~prev});
		wr_reg(MASTER_CONFIG_OFS, 8'h00);
		cycles(2);
		chk({6'h0, aux_oe, aux}, 8'h00);
		conclude();
	end
endmodule
`default_nettype wire
